// ### core/tste_pkg.sv
// Shared map, codes and timing of the socket transfer engine
package tste_pkg;
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_CMD     = 8'h00;
  localparam logic [ADR_W-1:0] OFS_STATE   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_EVT     = 8'h08;
  localparam logic [ADR_W-1:0] OFS_MASK    = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_COMMON  = 8'h10;
  localparam logic [ADR_W-1:0] OFS_RX_SIZE = 8'h14;
  localparam logic [ADR_W-1:0] OFS_RX_RPTR = 8'h18;
  localparam logic [ADR_W-1:0] OFS_TX_FREE = 8'h1c;
  localparam logic [ADR_W-1:0] OFS_TX_WPTR = 8'h20;
  localparam logic [ADR_W-1:0] OFS_TX_RPTR = 8'h24;
  localparam logic [ADR_W-1:0] OFS_RTY_IVL = 8'h28;
  localparam logic [ADR_W-1:0] OFS_RTY_LIM = 8'h2c;
  localparam logic [ADR_W-1:0] OFS_MSS     = 8'h30;
  localparam logic [ADR_W-1:0] OFS_DEST_IP = 8'h34;
  localparam logic [ADR_W-1:0] OFS_MODE    = 8'h38;

  typedef enum logic [7:0] {
    CMD_NONE     = 8'h00,
    CMD_OPEN     = 8'h01,
    CMD_CONNECT  = 8'h02,
    CMD_TEARDOWN = 8'h03,
    CMD_CLOSE    = 8'h04,
    CMD_SEND     = 8'h05,
    CMD_RX_DONE  = 8'h06
  } tste_cmd_e;

  typedef enum logic [7:0] {
    ST_CLOSED       = 8'h00,
    ST_INIT         = 8'h01,
    ST_SYN_SENT     = 8'h02,
    ST_ESTAB        = 8'h03,
    ST_PEER_CLOSING = 8'h04,
    ST_FIN_WAIT     = 8'h05,
    ST_UDP          = 8'h06
  } tste_sock_e;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_ARP  = 2'b01,
    E_SEG  = 2'b10,
    E_WAIT = 2'b11
  } tste_eng_e;

  localparam int EV_CON     = 0;
  localparam int EV_CMD_GRACEFUL_TEARDOWN  = 1;
  localparam int EV_RX      = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_SENDOK  = 4;
  localparam int MODE_UDP   = 0;

  localparam logic [15:0] RST_RTY_IVL = 16'h0010;
  localparam logic [7:0]  RST_RTY_LIM = 8'h04;
  localparam logic [15:0] RST_MSS     = 16'h0400;
  localparam logic [7:0]  RST_MASK    = 8'hff;
  localparam logic [31:0] BCAST_IP    = 32'hffffffff;

  localparam int CLK_PERIOD_NS = 5;
  localparam int RTY_UNIT_NS   = 100;
  localparam int RTY_UNIT_CYC  =
    (RTY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RTY_UNIT_LAST = 5'(RTY_UNIT_CYC - 1);

  typedef struct packed {
    logic        valid;
    logic        syn;
    logic        fin;
    logic [15:0] len;
  } tste_seg_s;
endpackage

// ### core/tste_core.sv
// Socket transfer engine: one socket, Wishbone registers, link events
`timescale 1ns/100ps
`default_nettype none
module tste_core
  import tste_pkg::*;
#(
  parameter logic [15:0] RX_SIZE = 16'h0800,
  parameter logic [15:0] TX_SIZE = 16'h0800
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq_o,
  input  wire logic             rx_seg_valid_i,
  input  wire logic [15:0]      rx_seg_len_i,
  input  wire logic             rx_fin_i,
  output logic                  rx_accept_o,
  output logic                  rx_pause_o,
  input  wire logic             peer_ack_i,
  input  wire logic             arp_done_i,
  output logic                  arp_req_o,
  output var tste_seg_s         tx_seg_o
);
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8],
               sel[0] ? dat[7:0]  : old[7:0]};
  endfunction

  logic [7:0]  cmd_q, ev_q, mask_q, lim_q, rcnt_q, rcnt_d, mode_q;
  logic [7:0]  ev_set, ev_all, ev_clr, ev_d;
  logic [15:0] rx_wr_q, rx_rel_q, rel_d, rx_rd_q, pend_q;
  logic [15:0] tx_wr_q, tx_rd_q, tx_rd_d, ivl_q, mss_q, sent_q, tcnt_q;
  logic [31:0] dip_q, rd_mux;
  logic [4:0]  ucnt_q;
  logic        cm_q, cm_d, pause_q, ack_q, done, emit, arp_d, restart;
  tste_sock_e  sock_q, sock_d, sock_n;
  tste_eng_e   eng_q, eng_d;

  // Bus decode
  wire req     = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr      = req & wb_we_i;
  wire wr_cmd  = wr & (wb_adr_i == OFS_CMD) & wb_sel_i[0];
  wire wr_evt  = wr & (wb_adr_i == OFS_EVT) & wb_sel_i[0];
  wire wr_mask = wr & (wb_adr_i == OFS_MASK) & wb_sel_i[0];
  wire wr_cm   = wr & (wb_adr_i == OFS_COMMON) & wb_sel_i[0];
  wire wr_rxrp = wr & (wb_adr_i == OFS_RX_RPTR);
  wire wr_txwp = wr & (wb_adr_i == OFS_TX_WPTR);
  wire wr_ivl  = wr & (wb_adr_i == OFS_RTY_IVL);
  wire wr_lim  = wr & (wb_adr_i == OFS_RTY_LIM) & wb_sel_i[0];
  wire wr_mss  = wr & (wb_adr_i == OFS_MSS);
  wire wr_dip  = wr & (wb_adr_i == OFS_DEST_IP);
  wire wr_mode = wr & (wb_adr_i == OFS_MODE) & wb_sel_i[0];

  // Buffer occupancy; pointers wrap freely at 16 bits
  wire [15:0] rcv_size = rx_wr_q - rx_rel_q;
  wire [15:0] rx_free  = RX_SIZE - rcv_size;
  wire [15:0] tx_pend  = tx_wr_q - tx_rd_q;
  wire [15:0] tx_free  = TX_SIZE - tx_pend;
  wire        is_udp   = mode_q[MODE_UDP];
  wire        tcp_data = (sock_q == ST_ESTAB) | (sock_q == ST_PEER_CLOSING);
  wire [15:0] seg_len  = is_udp ? tx_pend :
                         (tx_pend > mss_q) ? mss_q : tx_pend;
  wire        unicast  = dip_q != BCAST_IP;

  // Retry timer: units of RTY_UNIT_NS, ivl_q units per attempt
  wire tick    = ucnt_q == RTY_UNIT_LAST;
  wire expire  = tick & ((tcnt_q + 16'h0001) >= ivl_q);
  wire give_up = expire & (rcnt_q == lim_q);

  // Receive admission; a paused segment is retried against fresh space
  wire        rx_open = (sock_q == ST_ESTAB) | (sock_q == ST_UDP);
  wire        try_rx  = pause_q | (rx_seg_valid_i & rx_open);
  wire [15:0] try_len = pause_q ? pend_q : rx_seg_len_i;
  wire        accept  = try_rx & (try_len <= rx_free);
  wire        go_pause = try_rx & ~accept & ~is_udp & ~pause_q;

  always_comb begin
    eng_d   = eng_q;
    sock_d  = sock_q;
    ev_set  = 8'h00;
    done    = 1'b0;
    emit    = 1'b0;
    arp_d   = 1'b0;
    restart = 1'b0;
    rcnt_d  = rcnt_q;
    tx_rd_d = tx_rd_q;
    rel_d   = rx_rel_q;
    unique case (eng_q)
      E_IDLE: begin
        if (cmd_q != CMD_NONE) begin
          done    = 1'b1;
          restart = 1'b1;
          rcnt_d  = 8'h00;
          if (cmd_q == CMD_OPEN) begin
            sock_d = is_udp ? ST_UDP : ST_INIT;
          end else if (cmd_q == CMD_CONNECT && sock_q == ST_INIT) begin
            sock_d = ST_SYN_SENT;
            eng_d  = E_ARP;
            arp_d  = 1'b1;
            done   = 1'b0;
          end else if (cmd_q == CMD_TEARDOWN && tcp_data) begin
            sock_d = ST_FIN_WAIT;
            eng_d  = E_SEG;
            done   = 1'b0;
          end else if (cmd_q == CMD_CLOSE) begin
            sock_d = ST_CLOSED;
          end else if (cmd_q == CMD_RX_DONE) begin
            rel_d = rx_rd_q;
          end else if (cmd_q == CMD_SEND && tx_pend != 16'h0000 &&
                       (tcp_data || sock_q == ST_UDP)) begin
            done = 1'b0;
            if (is_udp && unicast) begin
              eng_d = E_ARP;
              arp_d = 1'b1;
            end else begin
              eng_d = E_SEG;
            end
          end
        end
      end
      E_ARP: begin
        if (arp_done_i) begin
          eng_d   = E_SEG;
          restart = 1'b1;
        end else if (give_up) begin
          ev_set[EV_TIMEOUT] = 1'b1;
          done  = 1'b1;
          eng_d = E_IDLE;
          if (sock_q == ST_SYN_SENT) begin
            sock_d = ST_CLOSED;
          end
        end else if (expire) begin
          rcnt_d  = rcnt_q + 8'h01;
          arp_d   = 1'b1;
          restart = 1'b1;
        end
      end
      E_SEG: begin
        emit    = 1'b1;
        restart = 1'b1;
        if (is_udp) begin
          tx_rd_d = tx_rd_q + tx_pend;
          ev_set[EV_SENDOK] = 1'b1;
          done  = 1'b1;
          eng_d = E_IDLE;
        end else begin
          eng_d = E_WAIT;
        end
      end
      E_WAIT: begin
        if (peer_ack_i) begin
          restart = 1'b1;
          rcnt_d  = 8'h00;
          eng_d   = E_IDLE;
          done    = 1'b1;
          if (sock_q == ST_SYN_SENT) begin
            sock_d = ST_ESTAB;
            ev_set[EV_CON] = 1'b1;
          end else if (sock_q == ST_FIN_WAIT) begin
            sock_d = ST_CLOSED;
            ev_set[EV_CMD_GRACEFUL_TEARDOWN] = 1'b1;
          end else begin
            tx_rd_d = tx_rd_q + sent_q;
            if (tx_pend != sent_q) begin
              eng_d = E_SEG;
              done  = 1'b0;
            end else begin
              ev_set[EV_SENDOK] = 1'b1;
            end
          end
        end else if (give_up) begin
          ev_set[EV_TIMEOUT] = 1'b1;
          sock_d = ST_CLOSED;
          done   = 1'b1;
          eng_d  = E_IDLE;
        end else if (expire) begin
          rcnt_d = rcnt_q + 8'h01;
          eng_d  = E_SEG;
        end
      end
    endcase
  end

  // peer FIN when nothing else moves the state
  assign sock_n = (rx_fin_i && sock_q == ST_ESTAB && sock_d == ST_ESTAB) ?
                  ST_PEER_CLOSING : sock_d;

  // write one clears; a same-cycle event wins
  assign ev_all = ev_set | (accept ? (8'h01 << EV_RX) : 8'h00);
  assign ev_clr = wr_evt ? wb_dat_i[7:0] : 8'h00;
  assign ev_d   = (ev_q & ~ev_clr) | ev_all;
  // common flag follows the socket events
  assign cm_d   = (|ev_all) |
                  (cm_q & ~(wr_cm & wb_dat_i[0]) & (|ev_d));

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (wb_adr_i)
      OFS_CMD:     rd_mux[7:0]  = cmd_q;
      OFS_STATE:   rd_mux[7:0]  = sock_q;
      OFS_EVT:     rd_mux[7:0]  = ev_q;
      OFS_MASK:    rd_mux[7:0]  = mask_q;
      OFS_COMMON:  rd_mux[0]    = cm_q;
      OFS_RX_SIZE: rd_mux[15:0] = rcv_size;
      OFS_RX_RPTR: rd_mux[15:0] = rx_rd_q;
      OFS_TX_FREE: rd_mux[15:0] = tx_free;
      OFS_TX_WPTR: rd_mux[15:0] = tx_wr_q;
      OFS_TX_RPTR: rd_mux[15:0] = tx_rd_q;
      OFS_RTY_IVL: rd_mux[15:0] = ivl_q;
      OFS_RTY_LIM: rd_mux[7:0]  = lim_q;
      OFS_MSS:     rd_mux[15:0] = mss_q;
      OFS_DEST_IP: rd_mux       = dip_q;
      OFS_MODE:    rd_mux[7:0]  = mode_q;
      default:     rd_mux       = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_q <= req;
      wb_dat_o <= req ? rd_mux : 32'h00000000;
    end
  end
  assign wb_ack_o = ack_q;

  // Host-written configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= RST_MASK;
      lim_q  <= RST_RTY_LIM;
      ivl_q  <= RST_RTY_IVL;
      mss_q  <= RST_MSS;
      dip_q  <= 32'h00000000;
      mode_q <= 8'h00;
      rx_rd_q <= 16'h0000;
      tx_wr_q <= 16'h0000;
    end else begin
      if (wr_mask) mask_q <= wb_dat_i[7:0];
      if (wr_lim)  lim_q  <= wb_dat_i[7:0];
      if (wr_mode) mode_q <= wb_dat_i[7:0];
      if (wr_ivl)  ivl_q  <= merge16(ivl_q, wb_dat_i, wb_sel_i);
      if (wr_mss)  mss_q  <= merge16(mss_q, wb_dat_i, wb_sel_i);
      if (wr_rxrp) rx_rd_q <= merge16(rx_rd_q, wb_dat_i, wb_sel_i);
      if (wr_txwp) tx_wr_q <= merge16(tx_wr_q, wb_dat_i, wb_sel_i);
      if (wr_dip)  dip_q  <= {merge16(dip_q[31:16], {16'h0000,
                              wb_dat_i[31:16]}, {2'b00, wb_sel_i[3:2]}),
                              merge16(dip_q[15:0], wb_dat_i, wb_sel_i)};
    end
  end

  // Engine, pointers and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_q  <= E_IDLE;
      sock_q <= ST_CLOSED;
      cmd_q  <= CMD_NONE;
      ev_q   <= 8'h00;
      cm_q   <= 1'b0;
      rcnt_q <= 8'h00;
      tx_rd_q  <= 16'h0000;
      rx_rel_q <= 16'h0000;
      irq_o  <= 1'b0;
    end else begin
      eng_q  <= eng_d;
      sock_q <= sock_n;
      ev_q   <= ev_d;
      cm_q   <= cm_d;
      rcnt_q <= rcnt_d;
      tx_rd_q  <= tx_rd_d;
      rx_rel_q <= rel_d;
      irq_o  <= |(ev_d & mask_q);
      // zero on completion; busy writes are ignored
      if (done)
        cmd_q <= CMD_NONE;
      else if (wr_cmd && cmd_q == CMD_NONE)
        cmd_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      ucnt_q <= 5'h00;
      tcnt_q <= 16'h0000;
    end else begin
      ucnt_q <= tick ? 5'h00 : ucnt_q + 5'h01;
      tcnt_q <= tick ? tcnt_q + 16'h0001 : tcnt_q;
    end
  end

  // Link side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_wr_q     <= 16'h0000;
      pend_q      <= 16'h0000;
      pause_q     <= 1'b0;
      rx_accept_o <= 1'b0;
      arp_req_o   <= 1'b0;
      tx_seg_o    <= '0;
      sent_q      <= 16'h0000;
    end else begin
      // accept when space, else pause a TCP segment (UDP drops it)
      if (accept) rx_wr_q <= rx_wr_q + try_len;
      if (go_pause) pend_q <= rx_seg_len_i;
      pause_q <= (go_pause | (pause_q & ~accept)) &
                 (sock_q != ST_CLOSED);
      rx_accept_o <= accept;
      arp_req_o   <= arp_d;
      tx_seg_o.valid <= emit;
      tx_seg_o.syn   <= emit & (sock_q == ST_SYN_SENT);
      tx_seg_o.fin   <= emit & (sock_q == ST_FIN_WAIT);
      tx_seg_o.len   <= (emit && tcp_data) || (emit && is_udp) ?
                        seg_len : 16'h0000;
      if (emit) sent_q <= tcp_data ? seg_len : 16'h0000;
    end
  end
  assign rx_pause_o = pause_q;

  rx_pause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (go_pause && sock_q == ST_ESTAB) |=> rx_pause_o && !rx_accept_o)
    else $error("receive did not pause on lack of space");
  rx_size_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (accept && rel_d == rx_rel_q) |=>
      rcv_size == $past(rcv_size) + $past(try_len))
    else $error("received size not advanced by segment length");
  seg_mss_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_seg_o.valid && !is_udp) |-> tx_seg_o.len <= mss_q)
    else $error("segment longer than MSS");
  tx_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_q == E_WAIT && peer_ack_i && tcp_data) |=>
      tx_rd_q == $past(tx_rd_q) + $past(sent_q))
    else $error("transmit read pointer not advanced");
  peer_fin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_fin_i && sock_q == ST_ESTAB && eng_q == E_IDLE &&
     cmd_q == CMD_NONE) |=> sock_q == ST_PEER_CLOSING)
    else $error("peer FIN not reported");
  teardown_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_q == E_WAIT && sock_q == ST_FIN_WAIT && peer_ack_i) |=>
      sock_q == ST_CLOSED && ev_q[EV_CMD_GRACEFUL_TEARDOWN] && cmd_q == CMD_NONE)
    else $error("teardown completion wrong");
  tcp_timeout_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_q == E_WAIT && !peer_ack_i && give_up) |=>
      sock_q == ST_CLOSED && ev_q[EV_TIMEOUT] && eng_q == E_IDLE)
    else $error("final timeout not raised");
  evt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_evt && wb_dat_i[7:0] == 8'hff && ev_all == 8'h00) |=>
      ev_q == 8'h00)
    else $error("event flags not cleared");
  irq_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(ev_q & mask_q) && mask_q == $past(mask_q)) |-> irq_o)
    else $error("enabled event without interrupt");
  bcast_arp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_q == E_IDLE && cmd_q == CMD_SEND && sock_q == ST_UDP &&
     !unicast) |=> !arp_req_o && eng_q != E_ARP)
    else $error("broadcast send requested resolution");
  common_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_q == 8'h00) |-> !cm_q)
    else $error("common flag set with no socket event");
  cmd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (eng_q == E_IDLE && cmd_q == CMD_CLOSE) |=>
      cmd_q == CMD_NONE && sock_q == ST_CLOSED)
    else $error("close command not completed");
endmodule
`default_nettype wire

// ### verif/tste_peer.sv
// Network-side peer: answers segments and address lookups
`timescale 1ns/100ps
`default_nettype none
module tste_peer
  import tste_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire tste_seg_s tx_seg_i,
  input  wire logic      arp_req_i,
  input  wire logic      mute_i,
  output logic           peer_ack_o,
  output logic           arp_done_o
);
  logic [3:0] ack_q;
  logic [3:0] arp_q;

  // Random latency so that both prompt and slow answers occur
  always_ff @(posedge clk_i) begin
    peer_ack_o <= 1'b0;
    arp_done_o <= 1'b0;
    if (rst_i) begin
      ack_q <= 4'h0;
      arp_q <= 4'h0;
    end else begin
      if (tx_seg_i.valid)
        ack_q <= 4'(1 + $urandom_range(8));
      else if (ack_q != 4'h0)
        ack_q <= ack_q - 4'h1;
      if (arp_req_i)
        arp_q <= 4'(1 + $urandom_range(8));
      else if (arp_q != 4'h0)
        arp_q <= arp_q - 4'h1;
      // A muted peer stays silent so retries run out
      if (ack_q == 4'h1)
        peer_ack_o <= !mute_i;
      if (arp_q == 4'h1)
        arp_done_o <= !mute_i;
    end
  end
endmodule
`default_nettype wire

// ### verif/tste_core_tb_top.sv
// Self-checking bench of the socket transfer engine
`timescale 1ns/100ps
`default_nettype none
module tste_core_tb_top;
  import tste_pkg::*;
  typedef struct {bit chk; logic [31:0] exp; string nm;} tste_note_s;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack, irq, rx_acc, rx_pau, p_ack, arp_d, arp_r;
  logic        rx_v = 1'b0;
  logic        rx_fin = 1'b0;
  logic        mute = 1'b0;
  logic [15:0] rx_len = 16'h0;
  logic [15:0] tx_wp = 16'h0;
  logic [15:0] tx_rp = 16'h0;
  logic [31:0] rd;
  tste_seg_s   seg;
  tste_note_s  note;
  tste_note_s  note_q[$];
  logic [15:0] seg_q[$];
  int          fails = 0;
  int          check_count = 0;
  int          seg_n = 0;
  int          arp_n = 0;
  int          syn_n = 0;
  int          fin_n = 0;
  int          n0;

  always #2.5 clk_i = ~clk_i;

  tste_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(4'hf), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .irq_o(irq), .rx_seg_valid_i(rx_v),
    .rx_seg_len_i(rx_len), .rx_fin_i(rx_fin), .rx_accept_o(rx_acc),
    .rx_pause_o(rx_pau), .peer_ack_i(p_ack), .arp_done_i(arp_d),
    .arp_req_o(arp_r), .tx_seg_o(seg));

  tste_peer peer (.clk_i(clk_i), .rst_i(rst_i), .tx_seg_i(seg),
    .arp_req_i(arp_r), .mute_i(mute), .peer_ack_o(p_ack),
    .arp_done_o(arp_d));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic hung(input string nm);
    check(nm, 32'h0, 32'h1);
    give_verdict();
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50)
      hung("wb_ack");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    note_q.push_back('{1'b1, e, nm});
    wb(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input tste_cmd_e c);
    int n;
    wb(1'b1, OFS_CMD, 32'(c));
    n = 0;
    do begin
      note_q.push_back('{1'b0, 32'h0, ""});
      wb(1'b0, OFS_CMD, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 400);
    if (n >= 400)
      hung("cmd_idle");
  endtask

  task automatic wait_seg();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (seg.valid !== 1'b1 && n < 200);
    if (n >= 200)
      hung("seg_valid");
  endtask

  task automatic rx_in(input logic [15:0] len, input logic acc,
                       input logic pau);
    @(posedge clk_i);
    rx_v <= 1'b1;
    rx_len <= len;
    @(posedge clk_i);
    rx_v <= 1'b0;
    @(posedge clk_i);
    check("rx_accept", 32'(rx_acc), 32'(acc));
    check("rx_pause", 32'(rx_pau), 32'(pau));
  endtask

  task automatic tx_go(input logic [15:0] len);
    tx_wp = tx_wp + len;
    wb(1'b1, OFS_TX_WPTR, 32'(tx_wp));
    cmd(CMD_SEND);
  endtask

  task automatic clr_evt();
    wb(1'b1, OFS_EVT, 32'hff);
    wb(1'b1, OFS_COMMON, 32'h1);
  endtask

  task automatic open_tcp();
    wb(1'b1, OFS_MODE, 32'h0);
    cmd(CMD_OPEN);
    rd_chk(OFS_STATE, 32'(ST_INIT), "state");
    n0 = syn_n;
    cmd(CMD_CONNECT);
    check("syn_sent", 32'(syn_n - n0), 32'h1);
    rd_chk(OFS_STATE, 32'(ST_ESTAB), "state");
    rd_chk(OFS_EVT, 32'h1 << EV_CON, "evt");
    check("irq", 32'(irq), 32'h1);
    wb(1'b1, OFS_EVT, 32'hff);
    rd_chk(OFS_EVT, 32'h0, "evt");
    rd_chk(OFS_COMMON, 32'h0, "common");
    check("irq", 32'(irq), 32'h0);
  endtask

  task automatic close_sock();
    clr_evt();
    cmd(CMD_CLOSE);
    rd_chk(OFS_STATE, 32'(ST_CLOSED), "state");
    mute <= 1'b0;
  endtask

  // Results are compared as they appear, against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && note_q.size() > 0) begin
      note = note_q.pop_front();
      if (note.chk)
        check(note.nm, wb_rdat, note.exp);
    end
    if (seg.valid === 1'b1) begin
      seg_n++;
      if (seg.syn === 1'b1)
        syn_n++;
      if (seg.fin === 1'b1)
        fin_n++;
      if (seg_q.size() > 0 && seg.syn !== 1'b1 && seg.fin !== 1'b1)
        check("seg_len", 32'(seg.len), 32'(seg_q.pop_front()));
    end
    if (arp_r === 1'b1)
      arp_n++;
  end

  initial begin
    logic [15:0] len;
    void'($urandom(32'h63d9));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_MASK, 32'(RST_MASK), "mask");
    rd_chk(OFS_RTY_IVL, 32'(RST_RTY_IVL), "rty_ivl");
    rd_chk(OFS_RTY_LIM, 32'(RST_RTY_LIM), "rty_lim");
    rd_chk(OFS_MSS, 32'(RST_MSS), "mss");
    rd_chk(OFS_STATE, 32'(ST_CLOSED), "state");
    rd_chk(8'h3c, 32'h0, "unmapped");
    // Short retry window keeps the timeout cases brief
    wb(1'b1, OFS_RTY_IVL, 32'h1);
    wb(1'b1, OFS_RTY_LIM, 32'h2);
    wb(1'b1, OFS_MSS, 32'h100);
    open_tcp();
    rx_in(16'h300, 1'b1, 1'b0);
    rd_chk(OFS_RX_SIZE, 32'h300, "rx_size");
    rx_in(16'h600, 1'b0, 1'b1);
    rx_in(16'h010, 1'b0, 1'b1);
    rd_chk(OFS_RX_SIZE, 32'h300, "rx_size");
    wb(1'b1, OFS_RX_RPTR, 32'h300);
    wb(1'b1, OFS_CMD, 32'(CMD_RX_DONE));
    n0 = 0;
    while (rx_acc !== 1'b1 && n0 < 20) begin
      @(posedge clk_i);
      n0++;
    end
    if (n0 >= 20)
      hung("rx_resume");
    check("rx_resume", 32'(rx_acc), 32'h1);
    rd_chk(OFS_RX_SIZE, 32'h600, "rx_size");
    clr_evt();
    for (int i = 0; i < 3; i++) begin
      len = (i == 0) ? 16'h100 : 16'(1 + $urandom_range(16'h7fe));
      for (int k = 0; k < len; k += 'h100)
        seg_q.push_back((len - k > 'h100) ? 16'h100 : 16'(len - k));
      rd_chk(OFS_TX_FREE, 32'h800, "tx_free");
      tx_go(len);
      tx_rp = tx_wp;
      rd_chk(OFS_TX_RPTR, 32'(tx_wp), "tx_rptr");
      rd_chk(OFS_EVT, 32'h1 << EV_SENDOK, "evt");
      clr_evt();
    end
    seg_q.push_back(16'h100);
    tx_wp = tx_wp + 16'h180;
    wb(1'b1, OFS_TX_WPTR, 32'(tx_wp));
    wb(1'b1, OFS_CMD, 32'(CMD_SEND));
    wait_seg();
    wait_seg();
    mute <= 1'b1;
    cmd(CMD_NONE);
    rd_chk(OFS_STATE, 32'(ST_CLOSED), "state");
    rd_chk(OFS_EVT, 32'h1 << EV_TIMEOUT, "evt");
    rd_chk(OFS_TX_RPTR, 32'(tx_wp - 16'h80), "tx_rptr");
    close_sock();
    // only the acknowledged part left the buffer; the rest stays pending
    tx_rp = tx_wp - 16'h80;
    open_tcp();
    @(posedge clk_i);
    rx_fin <= 1'b1;
    @(posedge clk_i);
    rx_fin <= 1'b0;
    rd_chk(OFS_STATE, 32'(ST_PEER_CLOSING), "state");
    n0 = fin_n;
    cmd(CMD_TEARDOWN);
    check("fin_sent", 32'(fin_n - n0), 32'h1);
    rd_chk(OFS_STATE, 32'(ST_CLOSED), "state");
    rd_chk(OFS_EVT, 32'h1 << EV_CMD_GRACEFUL_TEARDOWN, "evt");
    close_sock();
    wb(1'b1, OFS_MODE, 32'h1);
    cmd(CMD_OPEN);
    rd_chk(OFS_STATE, 32'(ST_UDP), "state");
    wb(1'b1, OFS_DEST_IP, $urandom & 32'h7fffffff);
    n0 = arp_n;
    // Bytes left over from the cut TCP send go out in this datagram too
    seg_q.push_back(16'h40 + tx_wp - tx_rp);
    tx_go(16'h40);
    tx_rp = tx_wp;
    rd_chk(OFS_EVT, 32'h1 << EV_SENDOK, "evt");
    check("arp_used", 32'(arp_n > n0), 32'h1);
    clr_evt();
    mute <= 1'b1;
    n0 = seg_n;
    tx_go(16'h20);
    rd_chk(OFS_EVT, 32'h1 << EV_TIMEOUT, "evt");
    rd_chk(OFS_STATE, 32'(ST_UDP), "state");
    check("seg_count", 32'(seg_n), 32'(n0));
    clr_evt();
    wb(1'b1, OFS_MASK, 32'h0);
    wb(1'b1, OFS_DEST_IP, BCAST_IP);
    n0 = arp_n;
    seg_q.push_back(16'h30 + tx_wp - tx_rp);
    tx_go(16'h30);
    rd_chk(OFS_EVT, 32'h1 << EV_SENDOK, "evt");
    check("arp_count", 32'(arp_n), 32'(n0));
    check("irq", 32'(irq), 32'h0);
    wb(1'b1, OFS_MASK, 32'hff);
    repeat (3) @(posedge clk_i);
    check("irq", 32'(irq), 32'h1);
    close_sock();
    give_verdict();
  end
endmodule
`default_nettype wire
